// ---- rtl/paged_sfr_space_decoder.sv ----
// Decoder for the paged register space of an 8-bit core, with page selector.
// Assumes one request per cycle from the core; peripheral registers lie outside.
`timescale 1ns/100ps

// Summary of operation
// RULE_01 - Direct accesses to 0x80..0xFF go to the register space, never data RAM.
// RULE_02 - Addresses with low nibble 0x0 or 0x8 accept bit access as well as byte access.
// RULE_03 - All other addresses accept byte access only and refuse bit access.
// RULE_04 - Software keeps away from unoccupied addresses, whose effect is undefined.
// RULE_05 - Reset clears the page selector so accesses target page 0x0.
// RULE_06 - All eight selector bits choose the page for reads, writes and modifies.
// RULE_07 - The selector is read/write at 0xA7 on every page.
// RULE_08 - Paging lets different registers share one address depending on page.
// RULE_09 - Page 0xF adds registers while a shared set decodes alike on both pages.
// RULE_10 - Software masks interrupts around a switch to page 0xF and back.
// RULE_11 - An undefined page makes page-specific addresses reserved; shared ones still answer.
module paged_sfr_space_decoder (
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic                  clkEn,
   input  wire psd_pkg::psd_req_s     req,
   input  wire logic [7:0]            periphRdata,
   output      psd_pkg::psd_strobe_s  strobe,
   output      psd_pkg::psd_resp_s    resp,
   output      logic [7:0]            registerPageSelect
);

   typedef struct packed {
      logic [7:0]           pageSel;
      logic                 pend;
      logic                 pendSpace;
      logic                 pendSelHit;
      logic                 pendBitOk;
      psd_pkg::psd_req_s    pendReq;
      psd_pkg::psd_strobe_s strobe;
      psd_pkg::psd_resp_s   resp;
   } psd_state_s;

   psd_state_s        state;
   psd_state_s        next_state;
   psd_pkg::psd_map_e mapClass;
   logic              pageIsDefault;
   logic              pageIsSecond;
   logic              decodeHit;
   logic [7:0]        selMod;

   // Map lookup one cycle behind the request; request held in pend stage
   psd_map_rom uMap (
      .clk_sys  (clk_sys),
      .clkEn    (clkEn),
      .index    (req.addr[6:0]),
      .mapClass (mapClass)
   );

   always_comb begin
      pageIsDefault = (state.pageSel == psd_pkg::PAGE_DEFAULT);   // [RULE_06]
      pageIsSecond  = (state.pageSel == psd_pkg::PAGE_SECONDARY); // [RULE_06]
      case (mapClass)
         psd_pkg::PSD_MAP_SHARED: decodeHit = 1'b1;                     // [RULE_09] [RULE_11]
         psd_pkg::PSD_MAP_PAGE0:  decodeHit = pageIsDefault;            // [RULE_08]
         psd_pkg::PSD_MAP_PAGEF:  decodeHit = pageIsDefault | pageIsSecond; // [RULE_08] [RULE_09]
         default:                 decodeHit = 1'b0;                     // [RULE_04]
      endcase
      selMod = state.pageSel;
      if (state.pendReq.bitOp) begin
         selMod[state.pendReq.bitSel] = state.pendReq.bitValue;
      end else begin
         selMod = state.pendReq.wdata;
      end
   end

   always_comb begin
      next_state = state;
      next_state.strobe = '0;
      next_state.resp   = '0;

      // Stage 1: capture request while map lookup runs
      next_state.pend      = req.valid;
      next_state.pendReq   = req;
      next_state.pendSpace = req.direct & (req.addr >= psd_pkg::SPACE_BASE);           // [RULE_01]
      next_state.pendSelHit = (req.addr == psd_pkg::PAGE_SEL_ADDR);                   // [RULE_07]
      next_state.pendBitOk = (req.addr[3:0] == psd_pkg::BIT_NIBBLE_LO) ||
                             (req.addr[3:0] == psd_pkg::BIT_NIBBLE_HI);                // [RULE_02] [RULE_03]

      // Stage 2: decode against current page
      if (state.pend) begin
         next_state.resp.valid   = 1'b1;
         next_state.resp.toSpace = state.pendSpace;                                   // [RULE_01]
         if (state.pendSpace) begin
            if (state.pendReq.bitOp && !state.pendBitOk) begin
               next_state.resp.bitRefused = 1'b1;                                     // [RULE_03]
            end else if (state.pendSelHit) begin
               next_state.resp.rdata = state.pageSel;                                 // [RULE_07]
               if (state.pendReq.write) begin
                  next_state.pageSel = selMod;                                        // [RULE_07] [RULE_02]
               end
            end else if (!decodeHit) begin
               next_state.resp.reserved = 1'b1;                                       // [RULE_11] [RULE_04]
            end else begin
               next_state.strobe.rd       = ~state.pendReq.write;
               next_state.strobe.wr       = state.pendReq.write;
               next_state.strobe.page     = pageIsSecond &
                                            (mapClass == psd_pkg::PSD_MAP_PAGEF);     // [RULE_08] [RULE_09]
               next_state.strobe.bitOp    = state.pendReq.bitOp;                      // [RULE_02]
               next_state.strobe.index    = state.pendReq.addr[6:0];
               next_state.strobe.bitSel   = state.pendReq.bitSel;
               next_state.strobe.wdata    = state.pendReq.wdata;
               next_state.strobe.bitValue = state.pendReq.bitValue;
            end
         end
      end

      // Read data from peripheral side one cycle after its read strobe
      if (state.strobe.rd) begin
         next_state.resp.valid = 1'b1;
         next_state.resp.toSpace = 1'b1;
         next_state.resp.rdata = periphRdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= '0;                                                                 // [RULE_05]
         state.pageSel <= psd_pkg::PAGE_SEL_RESET;                                    // [RULE_05]
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   assign strobe             = state.strobe;
   assign resp               = state.resp;
   assign registerPageSelect = state.pageSel;

endmodule

// ---- rtl/psd_pkg.sv ----
// Package for the paged register space decoder: offsets, pages, carriers.
// Assumes an 8-bit core issuing direct-addressed accesses on one clock.
package psd_pkg;

   localparam logic [7:0] SPACE_BASE      = 8'h80;
   localparam logic [7:0] PAGE_SEL_ADDR   = 8'hA7;
   localparam logic [7:0] PAGE_SEL_RESET  = 8'h00;
   localparam logic [7:0] PAGE_DEFAULT    = 8'h00;
   localparam logic [7:0] PAGE_SECONDARY  = 8'h0F;
   localparam logic [3:0] BIT_NIBBLE_LO   = 4'h0;
   localparam logic [3:0] BIT_NIBBLE_HI   = 4'h8;
   localparam int         MAP_DEPTH       = 128;

   // Decode class of one address: which pages decode it
   typedef enum logic [1:0] {
      PSD_MAP_NONE   = 2'h0,
      PSD_MAP_PAGE0  = 2'h1,
      PSD_MAP_PAGEF  = 2'h3,
      PSD_MAP_SHARED = 2'h2
   } psd_map_e;

   // Core-side request
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       bitOp;
      logic       direct;
      logic [7:0] addr;
      logic [2:0] bitSel;
      logic [7:0] wdata;
      logic       bitValue;
   } psd_req_s;

   // Decoded strobe to the peripheral register side
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       page;
      logic       bitOp;
      logic [6:0] index;
      logic [2:0] bitSel;
      logic [7:0] wdata;
      logic       bitValue;
   } psd_strobe_s;

   // Answer to the core
   typedef struct packed {
      logic       valid;
      logic       toSpace;
      logic       reserved;
      logic       bitRefused;
      logic [7:0] rdata;
   } psd_resp_s;

endpackage

// ---- rtl/psd_map_rom.sv ----
// Registered lookup of which page decodes each address of the register space.
// Assumes the caller presents the low seven address bits every enabled cycle.
`timescale 1ns/100ps
module psd_map_rom (
   input  wire logic                 clk_sys,
   input  wire logic                 clkEn,
   input  wire logic [6:0]           index,
   output      psd_pkg::psd_map_e    mapClass
);

   function automatic psd_pkg::psd_map_e classOf(input logic [7:0] a);
      psd_pkg::psd_map_e c;
      c = psd_pkg::PSD_MAP_PAGE0;
      case (a)
         8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hA7, 8'hA8, 8'hA9,
         8'hD0, 8'hE0, 8'hE6, 8'hE7, 8'hF0, 8'hF6, 8'hF7:
            c = psd_pkg::PSD_MAP_SHARED;
         8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97, 8'hA4, 8'hA5, 8'hA6,
         8'hBA, 8'hBD:
            c = psd_pkg::PSD_MAP_PAGEF;            // Overlaid on page 0 too
         8'hB4, 8'hE5:
            c = psd_pkg::PSD_MAP_NONE;
         default:
            c = psd_pkg::PSD_MAP_PAGE0;
      endcase
      return c;
   endfunction

   psd_pkg::psd_map_e table_q [psd_pkg::MAP_DEPTH];

   genvar g;
   generate
      for (g = 0; g < psd_pkg::MAP_DEPTH; g++) begin : gEntry
         assign table_q[g] = classOf(8'h80 | 8'(g));
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (clkEn) begin
         mapClass <= table_q[index];
      end
   end

endmodule

// ---- bench/psd_monitor.sv ----
// Port checker for the paged register space decoder.
// Assumes a bind to the decoder top; clkEn low pauses checks.
`timescale 1ns/100ps
module psd_monitor (
   input wire logic                 clk_sys,
   input wire logic                 sys_rst,
   input wire logic                 clkEn,
   input wire psd_pkg::psd_req_s    req,
   input wire logic [7:0]           periphRdata,
   input wire psd_pkg::psd_strobe_s strobe,
   input wire psd_pkg::psd_resp_s   resp,
   input wire logic [7:0]           registerPageSelect
);
   logic sp;
   logic pw;
   assign sp = req.valid && req.direct && req.addr[7];
   assign pw = sp && req.write && !req.bitOp && req.addr == 8'hA7;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst || !clkEn);
   space_route_a: assert property (sp |-> ##2 resp.valid && resp.toSpace) else $error("space miss");
   ram_route_a: assert property (req.valid && !sp |-> ##2 !resp.toSpace && !strobe.rd) else $error("ram hit");
   bit_refuse_a: assert property (sp && req.bitOp && req.addr[2:0] != 3'h0 |-> ##2 resp.bitRefused)
      else $error("bit kept");
   reset_page_a: assert property (disable iff (!clkEn) sys_rst |=> registerPageSelect == 8'h00)
      else $error("reset page");
   page_write_a: assert property (pw |-> ##2 registerPageSelect == $past(req.wdata, 2)) else $error("page set");
   page_hold_a: assert property ($changed(registerPageSelect) |-> $past(pw, 2)) else $error("page moved");
   page_strobe_a: assert property (strobe.rd && strobe.page |-> registerPageSelect == 8'h0F)
      else $error("page f strobe");
   read_data_a: assert property (strobe.rd |=> resp.valid && resp.rdata == $past(periphRdata))
      else $error("read data");
   cover property (strobe.rd && strobe.page);
   cover property (resp.valid && resp.reserved);
   cover property (resp.valid && resp.bitRefused);
endmodule

// ---- bench/psd_periph_model.sv ----
// Peripheral register side: reads return page and index.
// Assumes one-cycle read strobes; data holds two cycles after.
`timescale 1ns/100ps
module psd_periph_model (
   input  wire logic                 clk_sys,
   input  wire psd_pkg::psd_strobe_s strobe,
   output      logic [7:0]           periphRdata
);
   logic [7:0] last = 8'h5A;
   logic       hold = 1'b0;
   // Stale data scrambles every cycle except the two after a read strobe
   always @(posedge clk_sys) begin
      hold <= strobe.rd;
      last <= strobe.rd ? {strobe.page, strobe.index} : (hold ? last : ~last);
   end
   assign periphRdata = strobe.rd ? {strobe.page, strobe.index} : last;
endmodule

// ---- bench/paged_sfr_space_decoder_tb_top.sv ----
// Bench for the paged register space decoder; plays the core.
// Assumes the peripheral model answers reads.
`timescale 1ns/100ps
module paged_sfr_space_decoder_tb_top;
   logic                 clk_sys = 1'b0;
   logic                 sys_rst = 1'b1;
   logic                 clkEn = 1'b1;
   logic [7:0]           periphRdata, registerPageSelect, fl;
   psd_pkg::psd_req_s    req = '0;
   psd_pkg::psd_strobe_s strobe, st;
   psd_pkg::psd_resp_s   resp, rs, r3;
   int                   n_errors = 0, cmp_count = 0, cyc = 0;
   always #2 clk_sys = ~clk_sys;
   paged_sfr_space_decoder dut (.clk_sys, .sys_rst, .clkEn, .req, .periphRdata, .strobe, .resp, .registerPageSelect);
   psd_periph_model model (.clk_sys, .strobe, .periphRdata);
   task chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   // Flags: valid, space, reserved, bit refused, rd, wr, page
   task acc(input logic w, b, input logic [7:0] a, wd, input logic d = 1'b1);
      @(negedge clk_sys) req = '{1'b1, w, b, d, a, 3'h0, wd, 1'b1};
      @(negedge clk_sys) req.valid = 1'b0;
      // Decode answer and strobe stand for the one cycle after this edge
      @(posedge clk_sys) #1 rs = resp;
      st = strobe;
      fl = {rs.valid, rs.toSpace, rs.reserved, rs.bitRefused, strobe.rd, strobe.wr, strobe.page, 1'b0};
      @(posedge clk_sys) #1 r3 = resp;
   endtask
   task t_route;
      chk(registerPageSelect, 8'h00);
      acc(0, 0, 8'h7F, 8'h00);
      chk(fl, 8'h80);
      acc(0, 0, 8'h90, 8'h00, 1'b0);
      chk(fl, 8'h80);
      acc(0, 0, 8'hFF, 8'h00);
      chk(fl, 8'hC8);
      chk(r3.rdata, 8'h7F);
      acc(0, 0, 8'hB4, 8'h00);
      chk(fl, 8'hE0);
   endtask
   task t_bits;
      for (int i = 0; i < 16; i++) begin
         acc(1, 1, 8'hD0 + 8'(i), 8'h00);
         chk(fl, (i % 8 == 0) ? 8'hC4 : 8'hD0);
      end
      acc(1, 1, 8'hD8, 8'h00);
      chk({st.bitOp, st.bitValue, 3'h0, st.bitSel}, 8'hC0);
      chk({1'b0, st.index}, 8'h58);
      acc(1, 0, 8'hD3, 8'h00);
      chk(fl, 8'hC4);
      acc(1, 1, 8'hA7, 8'h0F);
      chk(registerPageSelect, 8'h00);
   endtask
   task t_page;
      acc(1, 0, 8'hA7, 8'h0F);
      chk(registerPageSelect, 8'h0F);
      acc(0, 0, 8'h91, 8'h00);
      chk(fl, 8'hCA);
      chk(r3.rdata, 8'h91);
      acc(1, 0, 8'h91, 8'h3C);
      chk(fl, 8'hC6);
      chk(st.wdata, 8'h3C);
      chk({st.page, st.index}, 8'h91);
      acc(0, 0, 8'hFF, 8'h00);
      chk(fl, 8'hE0);
      acc(0, 0, 8'hA7, 8'h00);
      chk(rs.rdata, 8'h0F);
      acc(1, 0, 8'hA7, 8'h00);
      acc(0, 0, 8'h91, 8'h00);
      chk(r3.rdata, 8'h11);
   endtask
   task t_badpage;
      acc(1, 0, 8'hA7, 8'h05);
      acc(0, 0, 8'hA7, 8'h00);
      chk(rs.rdata, 8'h05);
      acc(0, 0, 8'h91, 8'h00);
      chk(fl, 8'hE0);
      acc(0, 0, 8'hE0, 8'h00);
      chk(fl, 8'hC8);
      acc(1, 0, 8'hA7, 8'h00);
   endtask
   // Page write held while clock enable is low must not be taken
   task t_freeze;
      @(negedge clk_sys) clkEn = 1'b0;
      req = '{1'b1, 1'b1, 1'b0, 1'b1, 8'hA7, 3'h0, 8'h0F, 1'b1};
      repeat (3) @(negedge clk_sys);
      chk({7'h00, resp.valid}, 8'h00);
      req.valid = 1'b0;
      clkEn = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(registerPageSelect, 8'h00);
   endtask
   task end_of_test;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_route;
      t_bits;
      t_page;
      t_badpage;
      t_freeze;
      end_of_test;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         end_of_test;
      end
   end
endmodule
bind paged_sfr_space_decoder psd_monitor mon (.clk_sys, .sys_rst, .clkEn, .req, .periphRdata, .strobe, .resp,
   .registerPageSelect);
